// ==== etsr_host_model.sv ====
// Host controller model driving the slot register port
`timescale 1ns/100ps
module etsr_host_model
	import etsr_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Register port toward the slot
	output logic [7:0] reg_addr,
	output logic reg_wr_en,
	output logic [7:0] reg_wdata,
	output logic reg_rd_en,
	input wire logic [7:0] reg_rdata
);
	// ------------------------------------------------------------
	// Idle values at time zero
	// ------------------------------------------------------------
	initial begin
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_wdata = 8'h00;
		reg_rd_en = 1'b0;
	end

	// ------------------------------------------------------------
	// Bus cycles, one strobe cycle each
	// ------------------------------------------------------------
	// Single write; lines scrambled after release so stale data never helps
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(posedge clk_sys);
		#1;
		reg_wr_en = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	// Single read; data taken once the strobe edge has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(posedge clk_sys);
		#1;
		reg_rd_en = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule

// ==== etsr_hour_decode.sv ====
// Decoder of the stored BCD hour into a binary hour of day
`timescale 1ns/100ps
module etsr_hour_decode
	import etsr_pkg::*;
(
	// Hour code in, decoded hour out
	etsr_hour_if.dec hif
);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic [4:0] h12; // Tens plus units
	logic [4:0] h24; // Twenties plus tens plus units
	logic units_ok; // Units digit is BCD

	// Both hour formats evaluated, format bit picks one
	always_comb begin
		h12 = {1'b0, hif.hour_byte[3:0]};
		if (hif.hour_byte[ETSR_TENS_HOURS_BIT]) begin
			h12 = 5'(h12 + ETSR_HOURS_TEN);
		end
		h24 = h12;
		if (hif.hour_byte[ETSR_HALF_DAY_BIT]) begin
			h24 = 5'(h12 + ETSR_HOURS_TWENTY);
		end
		units_ok = (hif.hour_byte[3:0] <= ETSR_UNITS_MAX);
		if (hif.hour_byte[ETSR_HOUR_FMT_BIT]) begin
			// 12-hour, bit 5 is the half-day mark
			hif.hour_pm = hif.hour_byte[ETSR_HALF_DAY_BIT];
			hif.hour_ok = units_ok && (h12 != 5'h00) && (h12 <= ETSR_NOON);
			if (hif.hour_byte[ETSR_HALF_DAY_BIT]) begin
				hif.hour_bin = (h12 == ETSR_NOON) ? ETSR_NOON : 5'(h12 + ETSR_NOON);
			end else begin
				hif.hour_bin = (h12 == ETSR_NOON) ? 5'h00 : h12;
			end
		end else begin
			// 24-hour, bit 5 is the twenties digit
			hif.hour_bin = h24;
			hif.hour_pm = (h24 >= ETSR_NOON);
			hif.hour_ok = units_ok && (h24 <= ETSR_LAST_HOUR_24) &&
				!(hif.hour_byte[ETSR_HALF_DAY_BIT] && hif.hour_byte[ETSR_TENS_HOURS_BIT]);
		end
	end

endmodule

// ==== etsr_hour_if.sv ====
// Carrier between the slot registers and the hour decoder
`timescale 1ns/100ps
interface etsr_hour_if;
	logic [7:0] hour_byte; // Stored hour register
	logic [4:0] hour_bin; // Hour of day, 0 to 23
	logic hour_pm; // Afternoon indicator
	logic hour_ok; // Stored code is legal
	modport regs (output hour_byte, input hour_bin, input hour_pm, input hour_ok);
	modport dec (input hour_byte, output hour_bin, output hour_pm, output hour_ok);
endinterface

// ==== etsr_pkg.sv ====
// Constants shared by the event timestamp slot register bank
package etsr_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ETSR_OFS_HOUR = 8'h3B;
	localparam logic [7:0] ETSR_OFS_DATE = 8'h3C;
	localparam logic [7:0] ETSR_OFS_MONTH = 8'h3D;
	localparam logic [7:0] ETSR_OFS_YEAR = 8'h3E;
	localparam logic [7:0] ETSR_OFS_FLAGS = 8'h3F;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ETSR_HOUR_FMT_BIT = 6;
	localparam int ETSR_HALF_DAY_BIT = 5;
	localparam int ETSR_TENS_HOURS_BIT = 4;
	localparam int ETSR_CENTURY_BIT = 7;
	localparam int ETSR_LOW_BAT_BIT = 3;
	localparam int ETSR_TO_BACKUP_BIT = 2;
	localparam int ETSR_TO_MAIN_BIT = 1;
	localparam int ETSR_INPUT_EDGE_BIT = 0;

	// ------------------------------------------------------------
	// Implemented-bit masks, unused bits read zero
	// ------------------------------------------------------------
	localparam logic [7:0] ETSR_HOUR_MASK = 8'h7F;
	localparam logic [7:0] ETSR_DATE_MASK = 8'h3F;
	localparam logic [7:0] ETSR_MONTH_MASK = 8'h9F;
	localparam logic [7:0] ETSR_YEAR_MASK = 8'hFF;
	localparam logic [7:0] ETSR_FLAGS_MASK = 8'h0F;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] ETSR_HOUR_RST = 8'h00;
	localparam logic [7:0] ETSR_DATE_RST = 8'h00;
	localparam logic [7:0] ETSR_MONTH_RST = 8'h00;
	localparam logic [7:0] ETSR_YEAR_RST = 8'h00;
	localparam logic [7:0] ETSR_FLAGS_RST = 8'h00;

	// ------------------------------------------------------------
	// Hour arithmetic
	// ------------------------------------------------------------
	localparam logic [3:0] ETSR_UNITS_MAX = 4'h9;
	localparam logic [4:0] ETSR_HOURS_TEN = 5'h0A;
	localparam logic [4:0] ETSR_HOURS_TWENTY = 5'h14;
	localparam logic [4:0] ETSR_NOON = 5'h0C;
	localparam logic [4:0] ETSR_LAST_HOUR_24 = 5'h17;

endpackage

// ==== etsr_slot_regs.sv ====
// Event timestamp slot: hour, date, month, year and cause flags
`timescale 1ns/100ps
module etsr_slot_regs
	import etsr_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port behind the serial interface
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd_en,
	output logic [7:0] reg_rdata,
	// Current calendar from the clock core
	input wire logic [7:0] cal_hour,
	input wire logic [7:0] cal_date,
	input wire logic [7:0] cal_month,
	input wire logic [7:0] cal_year,
	// Timestamp trigger pulses
	input wire logic evt_input_edge,
	input wire logic evt_low_battery,
	input wire logic evt_to_backup,
	input wire logic evt_to_main,
	// Slot status
	output logic ts_captured,
	output logic [4:0] ts_hour_bin,
	output logic ts_pm,
	output logic ts_hour_ok
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] slot_hour_reg; // Captured hour
	logic [7:0] slot_date_reg; // Captured date
	logic [7:0] slot_month_reg; // Captured month and century
	logic [7:0] slot_year_reg; // Captured year
	logic [7:0] slot_cause_flags_reg; // Trigger causes
	logic [3:0] cause_next; // Causes of this cycle's event
	logic capture; // Any trigger this cycle

	// ------------------------------------------------------------
	// Event detection
	// ------------------------------------------------------------

	// Gather the triggers into their flag positions
	always_comb begin
		cause_next = 4'h0;
		cause_next[ETSR_LOW_BAT_BIT] = evt_low_battery;
		cause_next[ETSR_TO_BACKUP_BIT] = evt_to_backup;
		cause_next[ETSR_TO_MAIN_BIT] = evt_to_main;
		cause_next[ETSR_INPUT_EDGE_BIT] = evt_input_edge;
		capture = |cause_next;
	end

	// ------------------------------------------------------------
	// Slot registers
	// ------------------------------------------------------------

	// Hour: capture wins over a host write in the same cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			slot_hour_reg <= ETSR_HOUR_RST;
		end else if (capture) begin
			// Format bit travels with the captured hour
			slot_hour_reg <= cal_hour & ETSR_HOUR_MASK;
		end else if (reg_wr_en && reg_addr == ETSR_OFS_HOUR) begin
			slot_hour_reg <= reg_wdata & ETSR_HOUR_MASK;
		end
	end

	// Date: tens in 5:4, units in 3:0
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			slot_date_reg <= ETSR_DATE_RST;
		end else if (capture) begin
			slot_date_reg <= cal_date & ETSR_DATE_MASK;
		end else if (reg_wr_en && reg_addr == ETSR_OFS_DATE) begin
			slot_date_reg <= reg_wdata & ETSR_DATE_MASK;
		end
	end

	// Month: century in 7, tens in 4, units in 3:0
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			slot_month_reg <= ETSR_MONTH_RST;
		end else if (capture) begin
			slot_month_reg <= cal_month & ETSR_MONTH_MASK;
		end else if (reg_wr_en && reg_addr == ETSR_OFS_MONTH) begin
			slot_month_reg <= reg_wdata & ETSR_MONTH_MASK;
		end
	end

	// Year: tens in 7:4, units in 3:0
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			slot_year_reg <= ETSR_YEAR_RST;
		end else if (capture) begin
			slot_year_reg <= cal_year & ETSR_YEAR_MASK;
		end else if (reg_wr_en && reg_addr == ETSR_OFS_YEAR) begin
			slot_year_reg <= reg_wdata & ETSR_YEAR_MASK;
		end
	end

	// Flags: a new event replaces the causes, and beats a host write
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			slot_cause_flags_reg <= ETSR_FLAGS_RST;
		end else if (capture) begin
			slot_cause_flags_reg <= {4'h0, cause_next};
		end else if (reg_wr_en && reg_addr == ETSR_OFS_FLAGS) begin
			// Host may clear or preset the causes
			slot_cause_flags_reg <= reg_wdata & ETSR_FLAGS_MASK;
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------

	// Registered read; unmapped offsets return zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd_en) begin
			unique case (reg_addr)
				ETSR_OFS_HOUR: begin
					reg_rdata <= slot_hour_reg;
				end
				ETSR_OFS_DATE: begin
					reg_rdata <= slot_date_reg;
				end
				ETSR_OFS_MONTH: begin
					reg_rdata <= slot_month_reg;
				end
				ETSR_OFS_YEAR: begin
					reg_rdata <= slot_year_reg;
				end
				ETSR_OFS_FLAGS: begin
					reg_rdata <= slot_cause_flags_reg;
				end
				default: begin
					reg_rdata <= 8'h00;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Hour decode
	// ------------------------------------------------------------
	etsr_hour_if hour_bus (); // Link to the decoder

	// Hand the stored hour to the decoder
	assign hour_bus.hour_byte = slot_hour_reg;

	// Combinational BCD to binary hour
	etsr_hour_decode u_hour_decode (
		.hif (hour_bus.dec)
	);

	// Decoded hour registered onto the outputs
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ts_hour_bin <= 5'h00;
			ts_pm <= 1'b0;
			ts_hour_ok <= 1'b0;
		end else begin
			ts_hour_bin <= hour_bus.hour_bin;
			ts_pm <= hour_bus.hour_pm;
			ts_hour_ok <= hour_bus.hour_ok;
		end
	end

	// Capture strobe, one cycle after the trigger
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ts_captured <= 1'b0;
		end else begin
			ts_captured <= capture;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [4:0] exp24_chk; // Expected 24-hour value of stored code

	// Reference sum of the BCD digits
	always_comb begin
		exp24_chk = {1'b0, slot_hour_reg[3:0]};
		if (slot_hour_reg[ETSR_TENS_HOURS_BIT]) begin
			exp24_chk = 5'(exp24_chk + ETSR_HOURS_TEN);
		end
		if (slot_hour_reg[ETSR_HALF_DAY_BIT]) begin
			exp24_chk = 5'(exp24_chk + ETSR_HOURS_TWENTY);
		end
	end

	// A legal 12-hour code counts 1 to 12
	property p_fmt_12;
		@(posedge clk_sys) disable iff (rst)
		(ts_hour_ok && $past(slot_hour_reg[ETSR_HOUR_FMT_BIT]))
			|-> ($past(slot_hour_reg[4:0]) >= 5'h01 && $past(slot_hour_reg[4:0]) <= 5'h12);
	endproperty
	a_fmt_12: assert property (p_fmt_12) else $error("12-hour count outside 1-12");

	// In 12-hour mode the half-day bit becomes the afternoon output
	property p_half_day;
		@(posedge clk_sys) disable iff (rst)
		$past(slot_hour_reg[ETSR_HOUR_FMT_BIT], 1) |-> (ts_pm == $past(slot_hour_reg[5]));
	endproperty
	a_half_day: assert property (p_half_day) else $error("AM/PM output wrong");

	// Twenties digit lifts a legal 24-hour value to 20 or more
	property p_twenties;
		@(posedge clk_sys) disable iff (rst)
		(ts_hour_ok && !$past(slot_hour_reg[6]) && $past(slot_hour_reg[5]))
			|-> (ts_hour_bin >= ETSR_HOURS_TWENTY);
	endproperty
	a_twenties: assert property (p_twenties) else $error("Twenties digit lost");

	// 24-hour value is the sum of its digits
	property p_digits;
		@(posedge clk_sys) disable iff (rst)
		!slot_hour_reg[ETSR_HOUR_FMT_BIT] |=> (ts_hour_bin == $past(exp24_chk));
	endproperty
	a_digits: assert property (p_digits) else $error("Hour digits misdecoded");

	// Low-battery trigger sets bit 3, kept until replaced
	property p_low_bat;
		@(posedge clk_sys) disable iff (rst)
		evt_low_battery |=> slot_cause_flags_reg[ETSR_LOW_BAT_BIT]
			##1 (slot_cause_flags_reg[ETSR_LOW_BAT_BIT] || $past(capture)
			|| $past(reg_wr_en && reg_addr == ETSR_OFS_FLAGS));
	endproperty
	a_low_bat: assert property (p_low_bat) else $error("Low-battery cause not kept");

	// Backup switch sets bit 2
	property p_to_backup;
		@(posedge clk_sys) disable iff (rst)
		evt_to_backup |=> slot_cause_flags_reg[ETSR_TO_BACKUP_BIT] && ts_captured;
	endproperty
	a_to_backup: assert property (p_to_backup) else $error("Backup cause missing");

	// Main switch alone sets exactly bit 1
	property p_to_main;
		@(posedge clk_sys) disable iff (rst)
		(evt_to_main && !evt_low_battery && !evt_to_backup && !evt_input_edge)
			|=> (slot_cause_flags_reg == 8'h02);
	endproperty
	a_to_main: assert property (p_to_main) else $error("Main cause wrong");

	// Input edge sets bit 0, even against a host write
	property p_input_edge;
		@(posedge clk_sys) disable iff (rst)
		(evt_input_edge && reg_wr_en) |=> slot_cause_flags_reg[ETSR_INPUT_EDGE_BIT];
	endproperty
	a_input_edge: assert property (p_input_edge) else $error("Input cause lost");

	// Unused date bits 7:6 and month bit 6 read zero
	property p_layout;
		@(posedge clk_sys) disable iff (rst)
		(reg_rd_en && (reg_addr == ETSR_OFS_DATE || reg_addr == ETSR_OFS_MONTH))
			|=> (reg_rdata[6] == 1'b0) && ($past(reg_addr) == ETSR_OFS_MONTH || !reg_rdata[7]);
	endproperty
	a_layout: assert property (p_layout) else $error("Reserved bits read nonzero");

	// Trigger copies calendar, readable two cycles later
	property p_copy;
		@(posedge clk_sys) disable iff (rst)
		(capture && !evt_low_battery) ##1 (reg_rd_en && reg_addr == ETSR_OFS_YEAR && !capture)
			|=> (reg_rdata == $past(cal_year, 2));
	endproperty
	a_copy: assert property (p_copy) else $error("Calendar not copied");

	// Trigger beats a host write in the same cycle
	property p_capture_wins;
		@(posedge clk_sys) disable iff (rst)
		(capture && reg_wr_en && reg_addr == ETSR_OFS_YEAR)
			|=> (slot_year_reg == $past(cal_year));
	endproperty
	a_capture_wins: assert property (p_capture_wins) else $error("Write beat capture");

	// Plain year write keeps both BCD digits
	property p_year_write;
		@(posedge clk_sys) disable iff (rst)
		(reg_wr_en && reg_addr == ETSR_OFS_YEAR && !capture)
			|=> (slot_year_reg == $past(reg_wdata));
	endproperty
	a_year_write: assert property (p_year_write) else $error("Year write lost");

	// Plain hour write keeps bits 6:0, bit 7 reads zero
	property p_hour_write;
		@(posedge clk_sys) disable iff (rst)
		(reg_wr_en && reg_addr == ETSR_OFS_HOUR && !capture)
			|=> (!slot_hour_reg[7] && slot_hour_reg[6:0] == $past(reg_wdata[6:0]));
	endproperty
	a_hour_write: assert property (p_hour_write) else $error("Hour write wrong");

endmodule

// ==== tb_top.sv ====
// Self-checking bench for the event timestamp slot registers
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
	import etsr_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] evt; // Triggers: low, backup, main, edge
		logic [7:0] hr, dt, mo, yr; // Calendar at trigger
		logic [7:0] fl; // Expected flags
		logic [4:0] bin; // Expected binary hour
		logic pm, ok; // Expected status
	} etsr_row_t;
	logic clk_sys, rst;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr_en, reg_rd_en;
	logic [7:0] cal_hour, cal_date, cal_month, cal_year;
	logic [3:0] evt;
	logic ts_captured, ts_pm, ts_hour_ok;
	logic [4:0] ts_hour_bin;
	logic [7:0] d;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	logic [7:0] masks [5] = '{ETSR_HOUR_MASK, ETSR_DATE_MASK, ETSR_MONTH_MASK,
		ETSR_YEAR_MASK, ETSR_FLAGS_MASK};
	logic [7:0] rsts [5] = '{ETSR_HOUR_RST, ETSR_DATE_RST, ETSR_MONTH_RST,
		ETSR_YEAR_RST, ETSR_FLAGS_RST};
	etsr_row_t rows [6] = '{
		'{4'h2, 8'h65, 8'h31, 8'h92, 8'h24, 8'h02, 5'h11, 1'b1, 1'b1},
		'{4'h1, 8'h23, 8'h15, 8'h07, 8'h99, 8'h01, 5'h17, 1'b1, 1'b1},
		'{4'h8, 8'h52, 8'h01, 8'h12, 8'h00, 8'h08, 5'h00, 1'b0, 1'b1},
		'{4'h4, 8'h09, 8'h28, 8'h81, 8'h50, 8'h04, 5'h09, 1'b0, 1'b1},
		'{4'hF, 8'h12, 8'h30, 8'h10, 8'h01, 8'h0F, 5'h0C, 1'b1, 1'b1},
		'{4'h1, 8'h8A, 8'hC9, 8'h69, 8'h77, 8'h01, 5'h00, 1'b0, 1'b0}};

	// ------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------
	etsr_host_model u_etsr_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
		.reg_rdata(reg_rdata));
	etsr_slot_regs u_etsr_slot_regs (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
		.reg_rdata(reg_rdata), .cal_hour(cal_hour), .cal_date(cal_date),
		.cal_month(cal_month), .cal_year(cal_year), .evt_input_edge(evt[0]),
		.evt_to_main(evt[1]), .evt_to_backup(evt[2]), .evt_low_battery(evt[3]),
		.ts_captured(ts_captured), .ts_hour_bin(ts_hour_bin), .ts_pm(ts_pm),
		.ts_hour_ok(ts_hour_ok));

	// ------------------------------------------------------------
	// Clock and hang guard
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// Ceiling far above the roughly 150 cycles the tests need
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			final_report();
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Closing verdict
	task automatic final_report();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// One trigger cycle with calendar levels, capture pulse checked
	task automatic trig(input logic [3:0] e, input logic [7:0] h, dt, mo, yr);
		@(posedge clk_sys);
		#1;
		{cal_hour, cal_date, cal_month, cal_year} = {h, dt, mo, yr};
		evt = e;
		@(posedge clk_sys);
		#1;
		evt = 4'h0;
		`CHK(ts_captured, 1'b1)
		@(posedge clk_sys);
		#1;
		`CHK(ts_captured, 1'b0)
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		evt = 4'h0;
		{cal_hour, cal_date, cal_month, cal_year} = 32'h0;
		repeat (16) @(posedge clk_sys);
		#1;
		`CHK(ts_captured, 1'b0)
		rst = 1'b0;
		// Reset values of all five registers
		for (int i = 0; i < 5; i++) begin
			u_etsr_host_model.rd(ETSR_OFS_HOUR + 8'(i), d);
			`CHK(d, rsts[i])
		end
		$display("test reset done");
		// Table of captures
		foreach (rows[i]) begin
			trig(rows[i].evt, rows[i].hr, rows[i].dt, rows[i].mo, rows[i].yr);
			u_etsr_host_model.rd(ETSR_OFS_HOUR, d);
			`CHK(d, rows[i].hr & ETSR_HOUR_MASK)
			u_etsr_host_model.rd(ETSR_OFS_DATE, d);
			`CHK(d, rows[i].dt & ETSR_DATE_MASK)
			u_etsr_host_model.rd(ETSR_OFS_MONTH, d);
			`CHK(d, rows[i].mo & ETSR_MONTH_MASK)
			u_etsr_host_model.rd(ETSR_OFS_YEAR, d);
			`CHK(d, rows[i].yr)
			u_etsr_host_model.rd(ETSR_OFS_FLAGS, d);
			`CHK(d, rows[i].fl)
			`CHK(ts_hour_ok, rows[i].ok)
			if (rows[i].ok) begin
				`CHK(ts_hour_bin, rows[i].bin)
				`CHK(ts_pm, rows[i].pm)
			end
		end
		$display("test captures done");
		// Host writes of all ones, unused bits read zero
		for (int i = 0; i < 5; i++) begin
			u_etsr_host_model.wr(ETSR_OFS_HOUR + 8'(i), 8'hFF);
			u_etsr_host_model.rd(ETSR_OFS_HOUR + 8'(i), d);
			`CHK(d, masks[i])
		end
		// Unmapped offsets on both sides of the slot
		u_etsr_host_model.wr(8'h40, 8'hA5);
		u_etsr_host_model.rd(8'h40, d);
		`CHK(d, 8'h00)
		u_etsr_host_model.rd(8'h3A, d);
		`CHK(d, 8'h00)
		$display("test writes done");
		// Host write colliding with a trigger is lost
		fork
			u_etsr_host_model.wr(ETSR_OFS_YEAR, 8'h99);
			trig(4'h9, 8'h61, 8'h11, 8'h05, 8'h55);
		join
		u_etsr_host_model.rd(ETSR_OFS_YEAR, d);
		`CHK(d, 8'h55)
		u_etsr_host_model.rd(ETSR_OFS_FLAGS, d);
		`CHK(d, 8'h09)
		`CHK(ts_hour_bin, 5'h0D)
		`CHK(ts_pm, 1'b1)
		// Read issued the cycle after a trigger sees the new year
		fork
			trig(4'h2, 8'h07, 8'h22, 8'h03, 8'h42);
			begin
				@(posedge clk_sys);
				u_etsr_host_model.rd(ETSR_OFS_YEAR, d);
			end
		join
		`CHK(d, 8'h42)
		$display("test collision done");
		// Reset in mid-run clears the slot
		@(posedge clk_sys);
		#1;
		rst = 1'b1;
		@(posedge clk_sys);
		#1;
		rst = 1'b0;
		`CHK(ts_hour_bin, 5'h00)
		u_etsr_host_model.rd(ETSR_OFS_FLAGS, d);
		`CHK(d, ETSR_FLAGS_RST)
		u_etsr_host_model.rd(ETSR_OFS_HOUR, d);
		`CHK(d, ETSR_HOUR_RST)
		$display("test reset again done");
		final_report();
	end
endmodule
